// *** bench/sbf_tb.sv ***
`timescale 1ns/1ns
module testbench
  import sbf_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        ce        = 1'b1;  // Enabled, dropped low for two checks in t_tick
  logic        spi_cs_n  = 1'b1;  // Frame idle
  logic        spi_sclk  = 1'b1;  // Mode 3 idle level
  logic        spi_din   = 1'b0;
  logic        smp_valid = 1'b0;
  logic        flt_ready = 1'b0;
  logic [2:0]  smp_axis  = 3'h0;
  logic [31:0] smp_data  = 32'h0;
  logic        spi_dout, spi_dout_oe, sample_tick, smp_ready, flt_valid;
  logic [2:0]  flt_axis;
  logic [31:0] flt_data;
  int          n_errors  = 0;
  int          num_checks = 0;

  localparam int unsigned TB_TICK = 8;  // Short sample period for simulation

  always #2 ref_clk = ~ref_clk;

  sbf_filter #(.TICK_PERIOD(TB_TICK)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_din(spi_din), .spi_dout(spi_dout),
    .spi_dout_oe(spi_dout_oe), .sample_tick(sample_tick),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_axis(smp_axis),
    .smp_data(smp_data), .flt_valid(flt_valid), .flt_ready(flt_ready),
    .flt_axis(flt_axis), .flt_data(flt_data)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // A wait ran out
  task automatic hang;
    n_errors++;
    $display("wrong value handshake expected done seen timeout");
    print_verdict();
  endtask : hang

  // One 16-bit mode 3 frame, five clocks per phase
  task automatic spi(input logic [15:0] tx, output logic [15:0] rx);
    spi_cs_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk("spi_dout_oe", 32'h1, 32'(spi_dout_oe));
    for (int i = 15; i >= 0; i--)
    begin
      spi_sclk = 1'b0;
      spi_din  = tx[i];
      repeat (5) @(negedge ref_clk);
      rx[i]    = spi_dout;
      spi_sclk = 1'b1;
      repeat (5) @(negedge ref_clk);
    end
    spi_cs_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("spi_dout_oe idle", 32'h0, 32'(spi_dout_oe));
  endtask : spi

  // Register write, low byte then high byte
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    logic [15:0] d;
    spi({1'b1, a, v[7:0]}, d);
    spi({1'b1, a + 7'h01, v[15:8]}, d);
  endtask : wr

  // Register read, answer comes in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] d;
    spi({1'b0, a, 8'h00}, d);
    spi(16'h0000, v);
  endtask : rd

  // Offer one sample until taken
  task automatic push(input logic [2:0] ax, input logic [31:0] d);
    int k;
    smp_valid = 1'b1;
    smp_axis  = ax;
    smp_data  = d;
    for (k = 0; k < 20 && smp_ready !== 1'b1; k++) @(negedge ref_clk);
    if (k == 20)
      hang();
    @(negedge ref_clk);
    smp_valid = 1'b0;
  endtask : push

  // Take one filtered word
  task automatic pop(output logic [2:0] ax, output logic [31:0] d);
    int k;
    for (k = 0; k < 20 && flt_valid !== 1'b1; k++) @(negedge ref_clk);
    if (k == 20)
      hang();
    ax        = flt_axis;
    d         = flt_data;
    flt_ready = 1'b1;
    @(negedge ref_clk);
    flt_ready = 1'b0;
  endtask : pop

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] v;
    chk("flt_valid", 32'h0, 32'(flt_valid));
    for (int a = 0; a < 13; a++)
    begin
      rd(a < 12 ? ADDR_GYRO_X_OFFSET_LO + 7'(2 * a) : ADDR_SMOOTHING_FILTER_CONTROL, v);
      chk("reset value", 32'h0, 32'(v));
    end
  endtask : t_reset

  // Offsets with a carry from low into high word, every axis
  task automatic t_offsets;
    logic [15:0] v;
    logic [2:0]  ax;
    logic [31:0] d;
    for (int a = 0; a < 6; a++)
    begin
      wr(ADDR_GYRO_X_OFFSET_LO + 7'(4 * a), 16'hFFF0 + 16'(a));
      wr(ADDR_GYRO_X_OFFSET_HI + 7'(4 * a), 16'(a));
      rd(ADDR_GYRO_X_OFFSET_LO + 7'(4 * a), v);
      chk("offset lo", 32'hFFF0 + 32'(a), 32'(v));
      rd(ADDR_GYRO_X_OFFSET_HI + 7'(4 * a), v);
      chk("offset hi", 32'(a), 32'(v));
    end
    for (int a = 0; a < 6; a++)
    begin
      push(3'(a), 32'h20);
      pop(ax, d);
      chk("axis", 32'(a), 32'(ax));
      chk("corrected", {16'(a), 16'hFFF0 + 16'(a)} + 32'h20, d);
    end
    // Axis code 7 is served as gyro x
    push(3'h7, 32'h20);
    pop(ax, d);
    chk("axis code 7", 32'h0, 32'(ax));
    chk("axis code 7 data", 32'h0001_0010, d);
  endtask : t_offsets

  // Fill the buffer until refused, then drain
  task automatic t_fifo;
    logic [2:0]  ax;
    logic [31:0] d;
    for (int i = 0; i < 8; i++) push(3'h4, 32'(i));
    chk("smp_ready full", 32'h0, 32'(smp_ready));
    // Offer a ninth word that must be refused
    smp_valid = 1'b1;
    smp_data  = 32'h0000_0100;
    @(negedge ref_clk);
    chk("smp_ready refused", 32'h0, 32'(smp_ready));
    smp_valid = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      pop(ax, d);
      chk("drained", 32'h0004_FFF4 + 32'(i), d);
    end
    chk("flt_valid drained", 32'h0, 32'(flt_valid));
  endtask : t_fifo

  // Sample tick rate, then outputs with the enable low
  task automatic t_tick;
    int n;
    n = 0;
    repeat (3 * TB_TICK)
    begin
      @(negedge ref_clk);
      if (sample_tick === 1'b1)
        n++;
    end
    chk("sample_tick count", 32'h3, 32'(n));
    ce = 1'b0;
    @(negedge ref_clk);
    chk("smp_ready frozen", 32'h0, 32'(smp_ready));
    chk("flt_valid frozen", 32'h0, 32'(flt_valid));
    ce = 1'b1;
  endtask : t_tick

  // Reset in mid-run clears offsets, filter size and windows
  task automatic t_rerun;
    logic [15:0] v;
    logic [2:0]  ax;
    logic [31:0] d;
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("spi_dout_oe after reset", 32'h0, 32'(spi_dout_oe));
    rd(ADDR_ACCEL_Z_OFFSET_LO, v);
    chk("offset after reset", 32'h0, 32'(v));
    rd(ADDR_SMOOTHING_FILTER_CONTROL, v);
    chk("filter after reset", 32'h0, 32'(v));
    push(3'h2, 32'h55);
    pop(ax, d);
    chk("pass after reset", 32'h55, d);
  endtask : t_rerun

  // Unmapped place and unused control bits
  task automatic t_regs;
    logic [15:0] v;
    wr(7'h58, 16'hAAAA);
    rd(7'h58, v);
    chk("unmapped", 32'h0, 32'(v));
    wr(ADDR_SMOOTHING_FILTER_CONTROL, 16'hFFFF);
    rd(ADDR_SMOOTHING_FILTER_CONTROL, v);
    chk("filter ctrl", 32'h7, 32'(v));
  endtask : t_regs

  // Two and sixteen tap cascades on a zero-offset axis
  task automatic t_avg;
    logic [2:0]  ax;
    logic [31:0] d;
    logic [31:0] e2[3] = '{32'd1, 32'd3, 32'd4};
    wr(ADDR_GYRO_Z_OFFSET_LO, 16'h0000);
    wr(ADDR_GYRO_Z_OFFSET_HI, 16'h0000);
    wr(ADDR_SMOOTHING_FILTER_CONTROL, 16'h0001);
    for (int k = 0; k < 3; k++)
    begin
      push(3'h2, 32'd4);
      pop(ax, d);
      chk("two tap", e2[k], d);
    end
    wr(ADDR_SMOOTHING_FILTER_CONTROL, 16'h0004);
    for (int k = 1; k <= 31; k++)
    begin
      push(3'h2, 32'd256);
      pop(ax, d);
      if (k == 1 || k == 16 || k == 31)
        chk("sixteen tap", k == 31 ? 32'd256 : 32'(k * (k + 1) / 2), d);
    end
  endtask : t_avg

  initial
  begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_tick();
    t_offsets();
    t_fifo();
    t_regs();
    t_avg();
    t_rerun();
    print_verdict();
  end
endmodule : testbench

// *** hdl/sbf_fifo.sv ***
`timescale 1ns/1ns
module sbf_fifo
  import sbf_pkg::*;
#(
  parameter int unsigned WIDTH = 35,
  parameter int unsigned DEPTH = 8
)(
  // Clock, reset, enable
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_param
    $error("sbf_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage words
  logic [AW:0]      wr_ptr_ff;        // Write pointer with wrap bit
  logic [AW:0]      rd_ptr_ff;        // Read pointer with wrap bit
  logic             push;             // Word taken this cycle
  logic             pop;              // Word released this cycle

  // Full when pointers differ only in the wrap bit
  assign in_ready  = ce && !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                             (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
  assign out_valid = ce && (wr_ptr_ff != rd_ptr_ff);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

  // Storage write
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

endmodule : sbf_fifo

// *** hdl/sbf_filter.sv ***
// What this block does
// - Gyro x offset is lo word plus hi word
// - Gyro y and z have own offsets
// - Gyro offset bit weighs one output bit
// - Accel x offset is lo plus hi word
// - Accel y and z have own offsets
// - Accel offset bit weighs one output bit
// - Filter size B gives two-to-B taps
// - Two cascaded averaging stages, same tap count
// - Size code 100 gives sixteen taps
// - Cascade delays output by N-1 samples
// - Offset follows factory stage at 2000 Hz
`timescale 1ns/1ns
module sbf_filter
  import sbf_pkg::*;
#(
  parameter int unsigned DATA_W      = 32,
  parameter int unsigned FIFO_DEPTH  = 8,
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
)(
  // Clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Serial register port pins
  input  wire logic              spi_cs_n,
  input  wire logic              spi_sclk,
  input  wire logic              spi_din,
  output logic                   spi_dout,
  output logic                   spi_dout_oe,
  // Sample clock towards the factory correction stage
  output logic                   sample_tick,
  // Factory-corrected samples in
  input  wire logic              smp_valid,
  output logic                   smp_ready,
  input  wire logic [2:0]        smp_axis,
  input  wire logic [DATA_W-1:0] smp_data,
  // Filtered samples out
  output logic                   flt_valid,
  input  wire logic              flt_ready,
  output logic [2:0]             flt_axis,
  output logic [DATA_W-1:0]      flt_data
);

  localparam int unsigned TAPS = 1 << ((1 << FILT_SIZE_W) - 1); // Largest N
  localparam int unsigned PW   = $clog2(TAPS);                  // Pointer width
  localparam int unsigned SW   = DATA_W + PW + 1;               // Sum width
  localparam int unsigned TW   = $clog2(TICK_PERIOD + 1);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DATA_W != 32 || TICK_PERIOD < 2)
  begin : g_bad_param
    $error("sbf_filter: DATA_W must be 32 and TICK_PERIOD at least 2");
  end

  // Maps an address to an offset word slot, 12 when not an offset word
  function automatic logic [3:0] word_slot(input logic [6:0] addr);
    logic [6:0] rel;
    rel = addr - ADDR_GYRO_X_OFFSET_LO;
    if (addr < ADDR_GYRO_X_OFFSET_LO || addr > ADDR_ACCEL_Z_OFFSET_HI + 7'h01)
      word_slot = 4'hC;
    else
      word_slot = rel[4:1];
  endfunction : word_slot

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_ff;   // First stage, read only by second stage
  logic [2:0] pin_s2_ff;   // Safe copies: cs_n, sclk, din
  logic       sclk_d_ff;   // Previous safe sclk for edge detection

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_ff <= 3'h6;  // Idle pins: cs_n high, sclk high, din low
      pin_s2_ff <= 3'h6;
      sclk_d_ff <= 1'b1;
    end
    else if (ce)
    begin
      pin_s1_ff <= {spi_cs_n, spi_sclk, spi_din};
      pin_s2_ff <= pin_s1_ff;
      sclk_d_ff <= pin_s2_ff[1];
    end
  end

  logic cs_act;   // Frame in progress
  logic sclk_up;  // Rising edge: take a bit in
  logic sclk_dn;  // Falling edge: put a bit out
  assign cs_act  = !pin_s2_ff[2];
  assign sclk_up = cs_act && pin_s2_ff[1] && !sclk_d_ff;
  assign sclk_dn = cs_act && !pin_s2_ff[1] && sclk_d_ff;

  // ----------------------------------------------------------------
  // Serial frame receiver
  // ----------------------------------------------------------------
  logic [14:0] rx_ff;      // Bits taken so far
  logic [3:0]  bit_cnt_ff; // Bits taken in this frame
  logic        wr_stb;     // Byte write this cycle
  logic        rd_stb;     // Read request this cycle
  logic [15:0] frame;      // Whole frame at the last bit
  logic        frame_end;  // Last bit of a frame taken

  assign frame_end = sclk_up && (bit_cnt_ff == 4'(FRAME_BITS - 1));
  assign frame     = {rx_ff, pin_s2_ff[0]};
  assign wr_stb    = frame_end && frame[CMD_WRITE_BIT];
  assign rd_stb    = frame_end && !frame[CMD_WRITE_BIT];

  // Shift register and bit counter; only the counter restarts whenever cs_n is high
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_ff      <= '0;
      bit_cnt_ff <= '0;
    end
    else if (ce)
    begin
      if (!cs_act)
        bit_cnt_ff <= '0;
      else if (sclk_up)
      begin
        rx_ff      <= frame[14:0];
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end
  end

  logic [6:0] wr_addr;  // Byte address of a write
  logic [7:0] wr_byte;  // Data byte of a write
  assign wr_addr = frame[CMD_ADDR_MSB:CMD_ADDR_LSB];
  assign wr_byte = frame[7:0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]            off_lo_ff [NUM_AXES]; // Offset lower words
  logic [15:0]            off_hi_ff [NUM_AXES]; // Offset upper words
  logic [FILT_SIZE_W-1:0] filt_b_ff;            // Filter size B
  logic [3:0]             wr_slot;              // Offset slot of a write
  logic                   filt_wr;              // Write to filter control

  assign wr_slot = word_slot(wr_addr);
  assign filt_wr = wr_stb && (wr_addr == ADDR_SMOOTHING_FILTER_CONTROL);

  // Byte writes; each half takes effect at once
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_AXES; i++)
      begin
        off_lo_ff[i] <= OFFSET_RESET;
        off_hi_ff[i] <= OFFSET_RESET;
      end
      filt_b_ff <= FILT_SIZE_RESET;
    end
    else if (ce && wr_stb)
    begin
      if (wr_slot < 4'hC)
      begin
        // Even slot is lower word, odd slot upper word
        if (!wr_slot[0] && !wr_addr[0])
          off_lo_ff[wr_slot[3:1]][7:0]  <= wr_byte;
        else if (!wr_slot[0])
          off_lo_ff[wr_slot[3:1]][15:8] <= wr_byte;
        else if (!wr_addr[0])
          off_hi_ff[wr_slot[3:1]][7:0]  <= wr_byte;
        else
          off_hi_ff[wr_slot[3:1]][15:8] <= wr_byte;
      end
      else if (filt_wr)
        filt_b_ff <= wr_byte[FILT_SIZE_LSB +: FILT_SIZE_W];
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  logic [3:0]  rd_slot;   // Offset slot of a read
  logic [15:0] rd_value;  // Word addressed by a read frame
  logic [15:0] tx_ff;     // Word being shifted out
  logic [15:0] rd_buf_ff; // Answer held for the next frame
  logic        cs_d_ff;   // Previous frame state
  logic        dout_ff;   // Serial output bit

  assign rd_slot = word_slot(frame[CMD_ADDR_MSB:CMD_ADDR_LSB]);

  // Unmapped addresses and unused filter bits read as zero
  always_comb
  begin
    rd_value = '0;
    if (rd_slot < 4'hC)
      rd_value = rd_slot[0] ? off_hi_ff[rd_slot[3:1]] : off_lo_ff[rd_slot[3:1]];
    else if (frame[CMD_ADDR_MSB:CMD_ADDR_LSB+1] == ADDR_SMOOTHING_FILTER_CONTROL[6:1])
      rd_value = {13'h0000, filt_b_ff};
  end

  // Answer loads at frame start and shifts out on falling edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_buf_ff <= '0;
      tx_ff     <= '0;
      cs_d_ff   <= 1'b0;
      dout_ff   <= 1'b0;
    end
    else if (ce)
    begin
      cs_d_ff <= cs_act;
      if (rd_stb)
        rd_buf_ff <= rd_value;
      if (cs_act && !cs_d_ff)
        tx_ff <= rd_buf_ff;
      else if (sclk_dn)
      begin
        dout_ff <= tx_ff[15];
        tx_ff   <= {tx_ff[14:0], 1'b0};
      end
    end
  end

  assign spi_dout    = dout_ff;
  assign spi_dout_oe = cs_act;

  // ----------------------------------------------------------------
  // Internal sample clock
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt_ff; // Cycles since the last tick
  logic          tick_ff;     // Sample tick pulse

  // One pulse every TICK_PERIOD cycles
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end
    else if (ce)
    begin
      tick_ff <= (tick_cnt_ff == TW'(TICK_PERIOD - 1));
      tick_cnt_ff <= (tick_cnt_ff == TW'(TICK_PERIOD - 1)) ? '0 : tick_cnt_ff + 1'b1;
    end
  end

  assign sample_tick = tick_ff;

  // ----------------------------------------------------------------
  // Offset and cascaded averaging
  // ----------------------------------------------------------------
  logic signed [DATA_W-1:0] hist1_ff [NUM_AXES][TAPS]; // Stage 1 history
  logic signed [DATA_W-1:0] hist2_ff [NUM_AXES][TAPS]; // Stage 2 history
  logic signed [SW-1:0]     sum1_ff  [NUM_AXES];       // Stage 1 running sum
  logic signed [SW-1:0]     sum2_ff  [NUM_AXES];       // Stage 2 running sum
  logic [PW-1:0]            ptr_ff   [NUM_AXES];       // Oldest history slot
  logic [PW:0]              fill_ff  [NUM_AXES];       // Valid history depth
  logic [PW:0]              tap_n;                     // Taps per stage
  logic [2:0]               ax;                        // Axis being served
  logic signed [DATA_W-1:0] corr;                      // Offset-corrected sample
  logic signed [DATA_W-1:0] old1, old2;                // Samples leaving
  logic signed [SW-1:0]     nxt_sum1, nxt_sum2;        // Updated sums
  logic signed [DATA_W-1:0] avg1, avg2;                // Stage outputs
  logic                     take;                      // Sample accepted
  logic                     fifo_ready;                // Room in the FIFO

  assign tap_n     = (PW + 1)'(1) << filt_b_ff;
  assign ax        = (smp_axis < 3'(NUM_AXES)) ? smp_axis : 3'h0;
  assign smp_ready = fifo_ready;
  assign take      = smp_valid && fifo_ready;

  // Each stage averages N samples; the second smooths the first
  always_comb
  begin
    corr     = smp_data + $signed({off_hi_ff[ax], off_lo_ff[ax]});
    old1     = (fill_ff[ax] >= tap_n) ? hist1_ff[ax][ptr_ff[ax]] : '0;
    old2     = (fill_ff[ax] >= tap_n) ? hist2_ff[ax][ptr_ff[ax]] : '0;
    nxt_sum1 = sum1_ff[ax] + SW'(corr) - SW'(old1);
    avg1     = DATA_W'(nxt_sum1 >>> filt_b_ff);
    nxt_sum2 = sum2_ff[ax] + SW'(avg1) - SW'(old2);
    avg2     = DATA_W'(nxt_sum2 >>> filt_b_ff);
  end

  // Histories hold data only; the fill count masks stale entries
  always_ff @(posedge ref_clk)
  begin
    if (take)
    begin
      hist1_ff[ax][ptr_ff[ax]] <= corr;
      hist2_ff[ax][ptr_ff[ax]] <= avg1;
    end
  end

  // Sums and pointers; a size change restarts every window
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_AXES; i++)
      begin
        sum1_ff[i] <= '0;
        sum2_ff[i] <= '0;
        ptr_ff[i]  <= '0;
        fill_ff[i] <= '0;
      end
    end
    else if (ce)
    begin
      if (filt_wr)
      begin
        for (int i = 0; i < NUM_AXES; i++)
        begin
          sum1_ff[i] <= '0;
          sum2_ff[i] <= '0;
          ptr_ff[i]  <= '0;
          fill_ff[i] <= '0;
        end
      end
      else if (take)
      begin
        sum1_ff[ax] <= nxt_sum1;
        sum2_ff[ax] <= nxt_sum2;
        ptr_ff[ax]  <= (ptr_ff[ax] + 1'b1) & PW'(tap_n - 1'b1);
        if (fill_ff[ax] < tap_n)
          fill_ff[ax] <= fill_ff[ax] + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO
  // ----------------------------------------------------------------
  sbf_fifo #(
    .WIDTH (DATA_W + 3),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (smp_valid && !filt_wr),
    .in_ready  (fifo_ready),
    .in_data   ({ax, avg2}),
    .out_valid (flt_valid),
    .out_ready (flt_ready),
    .out_data  ({flt_axis, flt_data})
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_gx_lo_write;
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && wr_stb && wr_addr == ADDR_GYRO_X_OFFSET_LO)
      |=> off_lo_ff[0][7:0] == $past(wr_byte);
  endproperty
  a_gx_lo_write: assert property (p_gx_lo_write) else $error("gyro x low byte lost");

  property p_gy_hi_write;
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && wr_stb && wr_addr == ADDR_GYRO_Y_OFFSET_HI + 7'h01)
      |=> off_hi_ff[1][15:8] == $past(wr_byte) && $stable(off_hi_ff[2]);
  endproperty
  a_gy_hi_write: assert property (p_gy_hi_write) else $error("gyro y high byte lost");

  property p_ax_lo_write;
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && wr_stb && wr_addr == ADDR_ACCEL_X_OFFSET_LO + 7'h01)
      |=> off_lo_ff[3][15:8] == $past(wr_byte) && $stable(off_lo_ff[0]);
  endproperty
  a_ax_lo_write: assert property (p_ax_lo_write) else $error("accel x low word lost");

  property p_az_hi_write;
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && wr_stb && wr_addr == ADDR_ACCEL_Z_OFFSET_HI)
      |=> off_hi_ff[5][7:0] == $past(wr_byte);
  endproperty
  a_az_hi_write: assert property (p_az_hi_write) else $error("accel z high byte lost");

  property p_gyro_scale;
    @(posedge ref_clk) disable iff (!rst_n)
    (take && ax == 3'h2) |-> corr - smp_data == {off_hi_ff[2], off_lo_ff[2]};
  endproperty
  a_gyro_scale: assert property (p_gyro_scale) else $error("gyro offset misweighted");

  property p_accel_scale;
    @(posedge ref_clk) disable iff (!rst_n)
    (take && ax == 3'h4) |-> corr - smp_data == {off_hi_ff[4], off_lo_ff[4]};
  endproperty
  a_accel_scale: assert property (p_accel_scale) else $error("accel offset misweighted");

  property p_size16;
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && filt_wr && wr_byte[2:0] == 3'h4) |=> tap_n == 16 && fill_ff[0] == 0;
  endproperty
  a_size16: assert property (p_size16) else $error("size 100 not sixteen taps");

  property p_bypass;
    @(posedge ref_clk) disable iff (!rst_n)
    (take && filt_b_ff == 3'h0) |-> avg2 == corr && avg1 == corr;
  endproperty
  a_bypass: assert property (p_bypass) else $error("size zero not pass-through");

  property p_tick;
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && tick_ff) |=> !tick_ff [*2];
  endproperty
  a_tick: assert property (p_tick) else $error("sample tick too frequent");

  property p_stage_sum;
    @(posedge ref_clk) disable iff (!rst_n)
    (take && !filt_wr && filt_b_ff == 3'h1 && fill_ff[ax] == 2)
      |-> avg1 == DATA_W'((SW'(corr) + SW'(hist1_ff[ax][ptr_ff[ax] ^ 1'b1])) >>> 1);
  endproperty
  a_stage_sum: assert property (p_stage_sum) else $error("stage one average wrong");

  c_write:  cover property (@(posedge ref_clk) disable iff (!rst_n) wr_stb);
  c_read:   cover property (@(posedge ref_clk) disable iff (!rst_n) rd_stb);
  c_full:   cover property (@(posedge ref_clk) disable iff (!rst_n) smp_valid && !fifo_ready);
  c_filter: cover property (@(posedge ref_clk) disable iff (!rst_n) take && filt_b_ff == 3'h4);

endmodule : sbf_filter

// *** hdl/sbf_pkg.sv ***
package sbf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 250_000_000;    // ref_clk rate
  localparam int unsigned SAMPLE_HZ   = 2000;           // Internal sample rate
  localparam int unsigned TICK_CYCLES = CLK_HZ / SAMPLE_HZ; // Clocks per sample

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_GYRO_X_OFFSET_LO  = 7'h40;
  localparam logic [6:0] ADDR_GYRO_X_OFFSET_HI  = 7'h42;
  localparam logic [6:0] ADDR_GYRO_Y_OFFSET_LO  = 7'h44;
  localparam logic [6:0] ADDR_GYRO_Y_OFFSET_HI  = 7'h46;
  localparam logic [6:0] ADDR_GYRO_Z_OFFSET_LO  = 7'h48;
  localparam logic [6:0] ADDR_GYRO_Z_OFFSET_HI  = 7'h4A;
  localparam logic [6:0] ADDR_ACCEL_X_OFFSET_LO = 7'h4C;
  localparam logic [6:0] ADDR_ACCEL_X_OFFSET_HI = 7'h4E;
  localparam logic [6:0] ADDR_ACCEL_Y_OFFSET_LO = 7'h50;
  localparam logic [6:0] ADDR_ACCEL_Y_OFFSET_HI = 7'h52;
  localparam logic [6:0] ADDR_ACCEL_Z_OFFSET_LO = 7'h54;
  localparam logic [6:0] ADDR_ACCEL_Z_OFFSET_HI = 7'h56;
  localparam logic [6:0] ADDR_SMOOTHING_FILTER_CONTROL         = 7'h5C;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned   NUM_AXES        = 6;        // 3 gyro then 3 accel
  localparam int unsigned   FILT_SIZE_LSB   = 0;        // Filter size B position
  localparam int unsigned   FILT_SIZE_W     = 3;        // Filter size B width
  localparam logic [15:0]   OFFSET_RESET    = 16'h0000; // Offset word reset
  localparam logic [2:0]    FILT_SIZE_RESET = 3'h0;     // Filter bypassed
  localparam int unsigned   FRAME_BITS      = 16;       // Serial frame length
  localparam int unsigned   CMD_WRITE_BIT   = 15;       // Write flag in a frame
  localparam int unsigned   CMD_ADDR_MSB    = 14;       // Address field top
  localparam int unsigned   CMD_ADDR_LSB    = 8;        // Address field bottom

endpackage : sbf_pkg
